// file: tb_top.sv
// self-checking bench for the 8-bit timer over classic wishbone
// assumes a fast tick of 2 cycles and a slow-source tick of 12 set on the instance
`timescale 1ns/1ps
module tb_top;
   import ttpd_pkg::*;
   logic clk = 0, reset_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, irq, pin, owned, tIn;
   logic [7:0]  wbAdr = 8'h00;
   logic [3:0]  wbSel = 4'h1;
   logic [31:0] wbDatI = 32'h0, wbDatO, q;
   int errors = 0, cmpCount = 0, cycles = 0, n;

   ttpd_timer #(.SEL2_CYC(2), .SLOW_CYC(12)) uut (.clk(clk),
      .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .timerInput(tIn), .timer4Irq(irq), .port1Bit4(pin), .port1Bit4Owned(owned));
   ttpd_load_model load (.clk(clk), .pinLevel(pin), .pinOwned(owned), .timerInput(tIn));

   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= {24'h0, d};
      // no local limit: only the bench timeout ends a stuck access
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // cycles until the pin reads lvl, bounded
   task automatic waitPin(input logic lvl);
      n = 0;
      while (pin !== lvl && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bus(0, OFS_CONTROL, 0); check(q, 32'h0000_0000);
      bus(0, OFS_OUTFF, 0); check(q, 32'h0000_0000);
      check(pin, 1'b1);
      // interval timer, compare 3, fast select
      bus(1, OFS_COMPARE, 8'h03);
      bus(1, OFS_MASK, 8'h01);
      bus(1, OFS_CONTROL, 8'h12);
      repeat (12) begin
         bus(0, OFS_COUNT, 0); check(q[7:0] <= 8'h03, 1'b1);
      end
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check(irq, 1'b1);
      check(pin, 1'b1);
      bus(1, OFS_MASK, 8'h00);
      bus(0, OFS_STATUS, 0); check(q[0], 1'b1);
      repeat (20) @(posedge clk);
      check(irq, 1'b0);
      bus(0, OFS_STATUS, 0); check(q[0], 1'b1);
      // divider: start level 1 shows as a low pin, toggles every 2 ticks
      bus(1, OFS_CONTROL, 8'h0A);
      bus(1, OFS_COMPARE, 8'h01);
      bus(1, OFS_OUTFF, 8'h01);
      repeat (3) @(posedge clk);
      check(pin, 1'b0);
      bus(1, OFS_CONTROL, 8'h1A);
      waitPin(1'b1);
      waitPin(1'b0); check(n, 4);
      waitPin(1'b1); check(n, 4);
      bus(0, OFS_STATUS, 0); check(q[0], 1'b1);
      // first-stage prescaler doubles the tick: 8 cycles a phase once settled
      bus(1, OFS_CONTROL, 8'h5A);
      repeat (10) @(posedge clk);
      waitPin(1'b1);
      waitPin(1'b0);
      waitPin(1'b1); check(n, 8);
      // pwm: compare 0x40 gives 191 low ticks, rewrite lands a period later
      bus(1, OFS_CONTROL, 8'h00);
      bus(1, OFS_OUTFF, 8'h00);
      bus(1, OFS_COMPARE, 8'h40);
      bus(1, OFS_CONTROL, 8'h1E);
      waitPin(1'b0);
      waitPin(1'b1); check(n, 382);
      bus(1, OFS_COMPARE, 8'h80);
      waitPin(1'b0);
      waitPin(1'b1); check(n, 382);
      bus(0, OFS_STATUS, 0); check(q[0], 1'b1);
      waitPin(1'b0);
      // a match sets only the match bit; the read eats three cycles of the low phase
      bus(0, OFS_STATUS, 0); check(q[1:0], 2'b10);
      waitPin(1'b1); check(n, 251);
      // event counter on pin edges
      bus(1, OFS_CONTROL, 8'h00);
      bus(1, OFS_COMPARE, 8'h02);
      bus(0, OFS_STATUS, 0);
      bus(1, OFS_CONTROL, 8'h14);
      load.pulse(2);
      bus(0, OFS_COUNT, 0); check(q, 32'h0000_0002);
      load.pulse(1);
      bus(0, OFS_COUNT, 0); check(q, 32'h0000_0000);
      bus(0, OFS_STATUS, 0); check(q[0], 1'b1);
      // slow operation leaves only select 00; pwm with slow prescaler uses slow source
      bus(1, OFS_CONTROL, 8'h9E);
      repeat (30) @(posedge clk);
      bus(0, OFS_COUNT, 0); check(q, 32'h0000_0000);
      bus(1, OFS_CONTROL, 8'h3C);
      repeat (30) @(posedge clk);
      bus(0, OFS_COUNT, 0); check(q, 32'h0000_0002);
      bus(1, OFS_CONTROL, 8'h00);
      // unmapped place, then compare survives a second reset
      bus(1, 8'h20, 8'hA5);
      bus(0, 8'h20, 0); check(q, 32'h0000_0000);
      bus(1, OFS_COMPARE, 8'h5A);
      bus(1, OFS_OUTFF, 8'h01);
      // a write without lane 0 is acked but must not land
      wbSel <= 4'h0;
      bus(1, OFS_COMPARE, 8'hC3);
      wbSel <= 4'h1;
      bus(0, OFS_COMPARE, 0); check(q, 32'h0000_005A);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bus(0, OFS_COMPARE, 0); check(q, 32'h0000_005A);
      bus(0, OFS_OUTFF, 0); check(q, 32'h0000_0000);
      check(load.fallCount > 0, 1'b1);
      final_report();
   end
endmodule

// file: ttpd_load_model.sv
// load on the shared port pin, plus the source of the count input pin
// assumes the bench calls pulse just after a rising clock edge
`timescale 1ns/1ps
module ttpd_load_model (
   input  wire logic clk,
   input  wire logic pinLevel,
   input  wire logic pinOwned,
   output logic      timerInput
);
   // port latch held high, so a released pin reads 1
   wire seenLevel = pinOwned ? pinLevel : 1'b1;
   int  fallCount = 0;
   logic lastLevel = 1'b1;
   initial timerInput = 1'b0;
   always @(posedge clk) begin
      if (lastLevel && !seenLevel) begin
         fallCount++;
      end
      lastLevel = seenLevel;
   end
   // wide pulses so the two-stage synchroniser never misses one
   task automatic pulse(input int n);
      repeat (n) begin
         timerInput <= 1'b1;
         repeat (8) @(posedge clk);
         timerInput <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
endmodule

// file: ttpd_pin_sync.sv
// two-stage synchroniser with rising edge pulse for the timer input pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module ttpd_pin_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pinAsync,
   output logic      rise
);
   logic meta;
   logic stable;
   logic prev;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
         rise   <= 1'b0;
      end else begin
         meta   <= pinAsync;
         stable <= meta;
         prev   <= stable;
         rise   <= stable & ~prev;
      end
   end
endmodule

// file: ttpd_pkg.sv
// constants for the 8-bit timer with divider and pwm output
// assumes a 250 MHz system clock and a 32-bit classic wishbone slave port
package ttpd_pkg;

   // ----------------------------------------------------------
   // bus and register map
   // ----------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam logic [7:0]  OFS_CONTROL = 8'h00;
   localparam logic [7:0]  OFS_COMPARE = 8'h04;
   localparam logic [7:0]  OFS_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_MASK    = 8'h0C;
   localparam logic [7:0]  OFS_COUNT   = 8'h10;
   localparam logic [7:0]  OFS_OUTFF   = 8'h14;

   // ----------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------
   localparam int          CTL_CLKSEL_LSB = 0;
   localparam int          CTL_MODE_LSB   = 2;
   localparam int          CTL_START_BIT  = 4;
   localparam int          CTL_SLOWPS_BIT = 5;
   localparam int          CTL_FIRSTPS_BIT = 6;
   localparam int          CTL_SLOWOP_BIT = 7;
   localparam logic [7:0]  CTL_RESET      = 8'h00;

   localparam logic [1:0]  MODE_TIMER   = 2'h0;
   localparam logic [1:0]  MODE_EVENT   = 2'h1;
   localparam logic [1:0]  MODE_DIVIDER = 2'h2;
   localparam logic [1:0]  MODE_PWM     = 2'h3;

   localparam logic [1:0]  CLK_SEL_SLOW = 2'h0;
   localparam logic [1:0]  CLK_SEL_MID  = 2'h1;
   localparam logic [1:0]  CLK_SEL_FAST = 2'h2;

   // ----------------------------------------------------------
   // status / mask fields
   // ----------------------------------------------------------
   localparam int          STS_IRQ_BIT   = 0;
   localparam int          STS_MATCH_BIT = 1;
   localparam int          STS_W         = 2;
   localparam logic [1:0]  STS_RESET     = 2'h0;

   localparam logic [7:0]  COUNT_MAX     = 8'hFF;
   localparam logic [7:0]  COUNT_ZERO    = 8'h00;

   // ----------------------------------------------------------
   // count periods
   // ----------------------------------------------------------
   localparam real PERIOD_SEL0_US = 163.84;
   localparam real PERIOD_SEL1_US = 10.24;
   localparam real PERIOD_SEL2_US = 0.64;
   localparam real PERIOD_SLOW_US = 244.14;
   localparam real CLK_MHZ        = 250.0;

   localparam int  SEL0_CYC = int'(PERIOD_SEL0_US * CLK_MHZ);
   localparam int  SEL1_CYC = int'(PERIOD_SEL1_US * CLK_MHZ);
   localparam int  SEL2_CYC = int'(PERIOD_SEL2_US * CLK_MHZ);
   localparam int  SLOW_CYC = int'(PERIOD_SLOW_US * CLK_MHZ);

endpackage

// file: ttpd_tick_gen.sv
// count-clock generator: one pulse every 'period' system clocks
// assumes period is steady while enabled; zero period gives no ticks
`timescale 1ns/1ps
module ttpd_tick_gen (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        enable,
   input  wire logic [31:0] period,
   output logic             tick
);
   logic [31:0] count;
   wire         atEnd = (count >= period - 32'h0000_0001);

   always_ff @(posedge clk) begin
      if (!reset_n || !enable || period == 32'h0000_0000) begin
         count <= 32'h0000_0000;
         tick  <= 1'b0;
      end else begin
         count <= atEnd ? 32'h0000_0000 : count + 32'h0000_0001;
         tick  <= atEnd;
      end
   end
endmodule

// file: ttpd_timer.sv
// 8-bit timer: interval, event count, divider output and pwm output
// assumes classic wishbone master on clk; the shared port pin latch is
// set high by software before divider or pwm output is used
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

// How it works
// - compare register keeps contents through reset
// - four modes: timer, event, divider, pwm
// - timer mode: match raises irq, clears count
// - three clock selects, first prescaler doubles
// - slow prescaler or slow operation: code 00
// - divider mode: match toggles flop, clears count
// - pin shows inverted flop in divider/pwm
// - flop writable by software, reset to zero
// - divider mode: irq on every toggle
// - pwm has 8-bit resolution on internal clock
// - pwm: match toggles, overflow toggles and clears
// - pwm irq only on overflow
// - pwm compare double-buffered per period
// - start bit loads first pwm compare
module ttpd_timer #(
   parameter int SEL0_CYC = ttpd_pkg::SEL0_CYC,
   parameter int SEL1_CYC = ttpd_pkg::SEL1_CYC,
   parameter int SEL2_CYC = ttpd_pkg::SEL2_CYC,
   parameter int SLOW_CYC = ttpd_pkg::SLOW_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [ttpd_pkg::ADDR_W-1:0]   wb_adr_i,
   input  wire logic [ttpd_pkg::DATA_W-1:0]   wb_dat_i,
   input  wire logic [3:0]                    wb_sel_i,
   output logic      [ttpd_pkg::DATA_W-1:0]   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          timerInput,
   output logic                               timer4Irq,
   output logic                               port1Bit4,
   output logic                               port1Bit4Owned
);
   import ttpd_pkg::*;

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   logic [7:0]       timer4Control;
   logic [7:0]       timer4CompareValue;
   logic [7:0]       activeCompare;
   logic [7:0]       count;
   logic             outFlop;
   logic [STS_W-1:0] status;
   logic [STS_W-1:0] mask;

   // ----------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------
   wire        busReq     = wb_cyc_i & wb_stb_i;
   wire        busDone    = busReq & wb_ack_o;
   wire        wrLane0    = busDone & wb_we_i & wb_sel_i[0];
   wire        hitControl = (wb_adr_i == OFS_CONTROL);
   wire        hitCompare = (wb_adr_i == OFS_COMPARE);
   wire        hitStatus  = (wb_adr_i == OFS_STATUS);
   wire        hitMask    = (wb_adr_i == OFS_MASK);
   wire        hitCount   = (wb_adr_i == OFS_COUNT);
   wire        hitOutFlop = (wb_adr_i == OFS_OUTFF);
   wire        wrControl  = wrLane0 & hitControl;
   wire        wrCompare  = wrLane0 & hitCompare;
   wire        wrMask     = wrLane0 & hitMask;
   wire        wrOutFlop  = wrLane0 & hitOutFlop;
   wire        rdStatus   = busDone & ~wb_we_i & hitStatus;
   wire [7:0]  wrByte     = wb_dat_i[7:0];

   // ----------------------------------------------------------
   // control fields
   // ----------------------------------------------------------
   wire [1:0]  clockSelect = timer4Control[CTL_CLKSEL_LSB +: 2];
   wire [1:0]  mode        = timer4Control[CTL_MODE_LSB +: 2];
   wire        runShift    = timer4Control[CTL_START_BIT];
   wire        slowPrescaleSelect       = timer4Control[CTL_SLOWPS_BIT];
   wire        firstStagePrescaleSelect = timer4Control[CTL_FIRSTPS_BIT];
   wire        slowOperation            = timer4Control[CTL_SLOWOP_BIT];
   wire        startRise = wrControl & wrByte[CTL_START_BIT] & ~runShift;

   wire        isTimer   = (mode == MODE_TIMER);
   wire        isEvent   = (mode == MODE_EVENT);
   wire        isDivider = (mode == MODE_DIVIDER);
   wire        isPwm     = (mode == MODE_PWM);

   // ----------------------------------------------------------
   // count clock selection
   // ----------------------------------------------------------
   // only code 00 is usable when the slow source is forced
   wire        slowOnly  = slowOperation | (isPwm & slowPrescaleSelect);
   wire        useSlow   = slowOnly | (slowPrescaleSelect & clockSelect == CLK_SEL_SLOW);
   logic [31:0] basePeriod;
   logic [31:0] period;

   always_comb begin
      case (clockSelect)
         CLK_SEL_SLOW: basePeriod = 32'(SEL0_CYC);
         CLK_SEL_MID:  basePeriod = 32'(SEL1_CYC);
         CLK_SEL_FAST: basePeriod = 32'(SEL2_CYC);
         default:      basePeriod = 32'h0000_0000;
      endcase
   end

   always_comb begin
      if (slowOnly && clockSelect != CLK_SEL_SLOW) begin
         period = 32'h0000_0000;
      end else if (useSlow) begin
         period = 32'(SLOW_CYC);
      end else if (firstStagePrescaleSelect) begin
         period = {basePeriod[30:0], 1'b0};
      end else begin
         period = basePeriod;
      end
   end

   logic internalTick;
   logic pinRise;

   ttpd_tick_gen u_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .enable  (runShift & ~isEvent),
      .period  (period),
      .tick    (internalTick)
   );

   ttpd_pin_sync u_pin (
      .clk      (clk),
      .reset_n  (reset_n),
      .pinAsync (timerInput),
      .rise     (pinRise)
   );

   // ----------------------------------------------------------
   // counter and compare
   // ----------------------------------------------------------
   // event mode counts pin edges, the others the internal clock
   wire        step      = runShift & (isEvent ? pinRise : internalTick);
   wire [7:0]  matchValue = isPwm ? activeCompare : timer4CompareValue;
   wire        match     = step & (count == matchValue);
   wire        overflow  = step & isPwm & (count == COUNT_MAX);
   wire        clearOnMatch = match & ~isPwm;
   wire        matchToggle  = match & (isDivider | isPwm);
   wire        doToggle     = matchToggle ^ overflow;
   wire        irqEvent  = isPwm ? overflow : match;
   logic [7:0] next_count;

   always_comb begin
      if (!runShift) begin
         next_count = COUNT_ZERO;
      end else if (clearOnMatch || overflow) begin
         next_count = COUNT_ZERO;
      end else if (step) begin
         next_count = count + 8'h01;
      end else begin
         next_count = count;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count <= COUNT_ZERO;
      end else begin
         count <= next_count;
      end
   end

   // ----------------------------------------------------------
   // compare stages, no reset on purpose
   // ----------------------------------------------------------
   // the active stage only moves at start or at period end so the duty never glitches
   always_ff @(posedge clk) begin
      if (wrCompare) begin
         timer4CompareValue <= wrByte;
      end
      if (startRise || overflow) begin
         activeCompare <= timer4CompareValue;
      end
   end

   // ----------------------------------------------------------
   // control, mask, output flop
   // ----------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         timer4Control <= CTL_RESET;
         mask          <= STS_RESET;
      end else begin
         if (wrControl) begin
            timer4Control <= wrByte;
         end
         if (wrMask) begin
            mask <= wrByte[STS_W-1:0];
         end
      end
   end

   // a software write beats a same-cycle toggle: it sets the start level
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         outFlop <= 1'b0;
      end else if (wrOutFlop) begin
         outFlop <= wrByte[0];
      end else if (doToggle) begin
         outFlop <= ~outFlop;
      end
   end

   // ----------------------------------------------------------
   // shared port pin
   // ----------------------------------------------------------
   // idle level is high, matching the latch software must set
   wire        pinOwned  = isDivider | isPwm;
   wire        next_pin  = pinOwned ? ~outFlop : 1'b1;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         port1Bit4      <= 1'b1;
         port1Bit4Owned <= 1'b0;
      end else begin
         port1Bit4      <= next_pin;
         port1Bit4Owned <= pinOwned;
      end
   end

   // ----------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------
   // only bits actually returned by the read are cleared, and a new
   // event in the clearing cycle survives
   logic [STS_W-1:0] statusRead;
   wire  [STS_W-1:0] statusSet = {match, irqEvent};
   wire  [STS_W-1:0] statusClr = rdStatus ? statusRead : STS_RESET;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         status <= STS_RESET;
      end else begin
         status <= (status & ~statusClr) | statusSet;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         timer4Irq <= 1'b0;
      end else begin
         timer4Irq <= |(((status & ~statusClr) | statusSet) & mask);
      end
   end

   // ----------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------
   logic [7:0] readByte;

   always_comb begin
      readByte = 8'h00;
      if (hitControl) begin
         readByte = timer4Control;
      end else if (hitCompare) begin
         readByte = timer4CompareValue;
      end else if (hitStatus) begin
         readByte = {{(8 - STS_W){1'b0}}, status};
      end else if (hitMask) begin
         readByte = {{(8 - STS_W){1'b0}}, mask};
      end else if (hitCount) begin
         readByte = count;
      end else if (hitOutFlop) begin
         readByte = {7'h00, outFlop};
      end
   end

   // one wait state: ack rises the cycle after the request
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0000_0000;
         statusRead <= STS_RESET;
      end else begin
         wb_ack_o <= busReq & ~wb_ack_o;
         if (busReq && !wb_ack_o) begin
            wb_dat_o   <= {24'h00_0000, readByte};
            statusRead <= status;
         end
      end
   end

endmodule

// file: ttpd_timer_assertions.sv
// concurrent checks on the timer bus port, interrupt and shared pin
// assumes it is bound onto ttpd_timer and sees only its ports
`timescale 1ns/1ps
module ttpd_timer_assertions
   import ttpd_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        reset_n,
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire logic                        wb_we_i,
   input wire logic [ttpd_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [ttpd_pkg::DATA_W-1:0] wb_dat_i,
   input wire logic [3:0]                  wb_sel_i,
   input wire logic [ttpd_pkg::DATA_W-1:0] wb_dat_o,
   input wire logic                        wb_ack_o,
   input wire logic                        timerInput,
   input wire logic                        timer4Irq,
   input wire logic                        port1Bit4,
   input wire logic                        port1Bit4Owned
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire busReq = wb_cyc_i & wb_stb_i;
   wire ctlWr  = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_CONTROL);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_prompt: assert property (busReq && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_cause: assert property (wb_ack_o |-> $past(busReq))
      else $error("ack without request");
   chk_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > OFS_OUTFF
      |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
   chk_pin_idle: assert property (!port1Bit4Owned |-> port1Bit4)
      else $error("pin low while not owned");
   chk_pin_quiet: assert property ($changed(port1Bit4) |->
      port1Bit4Owned || $past(port1Bit4Owned)) else $error("pin moved outside output modes");
   chk_owned_set: assert property (ctlWr && wb_dat_i[3] |-> ##[1:2] port1Bit4Owned)
      else $error("pin not taken in divider or pwm mode");
   chk_owned_clear: assert property (ctlWr && !wb_dat_i[3] |-> ##[1:2] !port1Bit4Owned)
      else $error("pin still taken in timer or event mode");
   chk_irq_hold: assert property (timer4Irq && !wb_ack_o && !$past(wb_ack_o) |=> timer4Irq)
      else $error("interrupt dropped without a bus access");

   cover property ($rose(timer4Irq));
   cover property ($fell(port1Bit4));
   cover property (ctlWr && wb_dat_i[3:2] == MODE_PWM);
endmodule

bind ttpd_timer ttpd_timer_assertions u_chk (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timerInput(timerInput),
   .timer4Irq(timer4Irq), .port1Bit4(port1Bit4), .port1Bit4Owned(port1Bit4Owned));
